// ---- rtl/pmc_power_mode_controller.sv ----
// Power mode controller: clock gating, doze, nap and sleep sequencing
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module pmc_power_mode_controller #(
  parameter int UNITS = pmc_pkg::UNIT_COUNT,
  parameter int DEC_WIDTH = pmc_pkg::DEC_W
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic cfg_we_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] hw_config_register_o,
  input wire logic pow_invoke_i,
  input wire logic [UNITS-1:0] unit_need_i,
  output logic [UNITS-1:0] unit_clk_en_o,
  input wire logic ext_interrupt_i,
  input wire logic system_mgmt_interrupt_i,
  input wire logic machine_check_pin_i,
  input wire logic machine_check_i,
  input wire logic perf_mon_interrupt_i,
  input wire logic thermal_interrupt_i,
  input wire logic soft_reset_i,
  input wire logic hard_reset_pin_i,
  input wire logic dec_load_i,
  input wire logic [DEC_WIDTH-1:0] dec_value_i,
  output logic [DEC_WIDTH-1:0] dec_count_o,
  output logic dec_interrupt_o,
  input wire logic snoop_hit_i,
  output logic quiesce_request_o,
  input wire logic quiesce_acknowledge_i,
  input wire logic bus_clk_en_i,
  output logic snoop_enable_o,
  output logic dcache_enable_o,
  output logic writeback_o,
  output logic timebase_run_o,
  output logic pll_keep_lock_o,
  output logic smi_vector_take_o,
  output logic ext_vector_take_o,
  output logic wake_o,
  output logic [2:0] mode_o
);
  //////////////////////////////////////////////////////////////////////
  pmc_pkg::pmc_state_type state_reg, state_next;
  logic [31:0] cfg_reg, cfg_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [3:0] qlow_reg, qlow_next;
  logic [DEC_WIDTH-1:0] dec_reg, dec_next;
  logic dec_irq_reg, dec_irq_next;
  logic smi_reg, smi_next, ext_reg, ext_next;
  logic wake_reg, wake_next;
  logic [2:0] sel;
  logic one_hot;
  logic doze_wake, nap_wake, sleep_wake, any_reset;

  assign sel = {cfg_reg[pmc_pkg::SLEEP_BIT], cfg_reg[pmc_pkg::NAP_BIT],
    cfg_reg[pmc_pkg::DOZE_BIT]};
  assign one_hot = (sel == 3'h1) || (sel == 3'h2) || (sel == 3'h4);
  assign any_reset = soft_reset_i;
  assign doze_wake = ext_interrupt_i | system_mgmt_interrupt_i | machine_check_pin_i |
    dec_irq_reg | perf_mon_interrupt_i | machine_check_i | thermal_interrupt_i |
    any_reset;
  assign nap_wake = ext_interrupt_i | system_mgmt_interrupt_i | machine_check_pin_i |
    machine_check_i | dec_irq_reg | any_reset;
  assign sleep_wake = ext_interrupt_i | system_mgmt_interrupt_i | machine_check_pin_i |
    any_reset;

  //////////////////////////////////////////////////////////////////////
  // Configuration register, decrementer and interrupt capture
  always_comb
  begin
    cfg_next = cfg_reg;
    if (hard_reset_pin_i)
      cfg_next = pmc_pkg::CFG_RESET;
    else if (cfg_we_i)
      cfg_next = cfg_wdata_i;
    dec_next = dec_reg;
    dec_irq_next = dec_irq_reg;
    if (dec_load_i)
      dec_next = dec_value_i;
    else if (state_reg != pmc_pkg::PMC_SLEEP)
    begin
      dec_next = dec_reg - 1'b1;
      if (dec_reg == '0)
        dec_irq_next = 1'b1;
    end
    // Wake consumes the event; a new expiry in that cycle still wins
    if (wake_reg && !(dec_reg == '0 && state_reg != pmc_pkg::PMC_SLEEP && !dec_load_i))
      dec_irq_next = 1'b0;
    smi_next = system_mgmt_interrupt_i;
    ext_next = ext_interrupt_i;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_reg <= pmc_pkg::CFG_RESET;
      dec_reg <= '1;
      dec_irq_reg <= 1'b0;
      smi_reg <= 1'b0;
      ext_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      dec_reg <= dec_next;
      dec_irq_reg <= dec_irq_next;
      smi_reg <= smi_next;
      ext_reg <= ext_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wake_next = 1'b0;
    qlow_next = qlow_reg;
    // Acknowledge clears the count at once, so a count saved up in full power
    // cannot open snooping on the first nap cycle
    if (quiesce_acknowledge_i)
      qlow_next = 4'h0;
    else if (bus_clk_en_i && qlow_reg != 4'(pmc_pkg::QUIESCE_ACKNOWLEDGE_LOW_BUS_CYCLES))
      qlow_next = qlow_reg + 4'h1;
    case (state_reg)
      pmc_pkg::PMC_FULL:
      begin
        cnt_next = 3'h0;
        if (pow_invoke_i && one_hot)
          state_next = pmc_pkg::PMC_ENTER;
      end
      pmc_pkg::PMC_ENTER:
      begin
        cnt_next = cnt_reg + 3'h1;
        if (!sel[0] && (sel[1] | sel[2]))
          state_next = pmc_pkg::PMC_QUIESCE;
        else if (cnt_reg == 3'(pmc_pkg::ENTRY_CYCLES - 1))
          state_next = pmc_pkg::PMC_DOZE;
      end
      pmc_pkg::PMC_QUIESCE:
      begin
        if (quiesce_acknowledge_i)
          state_next = sel[2] ? pmc_pkg::PMC_SLEEP : pmc_pkg::PMC_NAP;
      end
      pmc_pkg::PMC_DOZE:
      begin
        cnt_next = 3'h0;
        if (snoop_hit_i)
          state_next = pmc_pkg::PMC_SNOOP;
      end
      pmc_pkg::PMC_SNOOP:
      begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == 3'(pmc_pkg::SNOOP_WB_CYCLES - 1))
          state_next = pmc_pkg::PMC_DOZE;
      end
      default:
        state_next = state_reg;
    endcase
    // Wake always lands in full power, never another saving mode
    if ((state_reg == pmc_pkg::PMC_DOZE || state_reg == pmc_pkg::PMC_SNOOP) && doze_wake)
    begin
      state_next = pmc_pkg::PMC_FULL;
      wake_next = 1'b1;
    end
    if (state_reg == pmc_pkg::PMC_NAP && nap_wake)
    begin
      state_next = pmc_pkg::PMC_FULL;
      wake_next = 1'b1;
    end
    if ((state_reg == pmc_pkg::PMC_SLEEP || state_reg == pmc_pkg::PMC_QUIESCE) && sleep_wake)
    begin
      state_next = pmc_pkg::PMC_FULL;
      wake_next = 1'b1;
    end
    if (hard_reset_pin_i)
      state_next = pmc_pkg::PMC_FULL;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= pmc_pkg::PMC_FULL;
      cnt_reg <= 3'h0;
      qlow_reg <= 4'h0;
      wake_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      qlow_reg <= qlow_next;
      wake_reg <= wake_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Unit clock gating
  pmc_gate_if #(.N(UNITS)) gif ();
  assign gif.gating_en = cfg_reg[pmc_pkg::GATING_BIT];
  assign gif.core_run = (state_reg == pmc_pkg::PMC_FULL) || (state_reg == pmc_pkg::PMC_ENTER);
  assign gif.unit_need = unit_need_i;
  pmc_unit_gate #(.N(UNITS)) u_gate (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .g(gif.gate)
  );
  assign unit_clk_en_o = gif.unit_clk_en;

  //////////////////////////////////////////////////////////////////////
  assign hw_config_register_o = cfg_reg;
  assign dec_count_o = dec_reg;
  assign dec_interrupt_o = dec_irq_reg;
  assign quiesce_request_o = (state_reg == pmc_pkg::PMC_QUIESCE) ||
    (state_reg == pmc_pkg::PMC_NAP) || (state_reg == pmc_pkg::PMC_SLEEP);
  assign snoop_enable_o = (state_reg != pmc_pkg::PMC_SLEEP) && ((state_reg != pmc_pkg::PMC_NAP)
    || (qlow_reg == 4'(pmc_pkg::QUIESCE_ACKNOWLEDGE_LOW_BUS_CYCLES)));
  assign dcache_enable_o = (state_reg == pmc_pkg::PMC_FULL) ||
    (state_reg == pmc_pkg::PMC_ENTER) || (state_reg == pmc_pkg::PMC_SNOOP);
  assign writeback_o = (state_reg == pmc_pkg::PMC_SNOOP);
  assign timebase_run_o = (state_reg != pmc_pkg::PMC_SLEEP);
  assign pll_keep_lock_o = (state_reg != pmc_pkg::PMC_SLEEP);
  assign smi_vector_take_o = system_mgmt_interrupt_i & ~smi_reg;
  assign ext_vector_take_o = ext_interrupt_i & ~ext_reg;
  assign wake_o = wake_reg;
  assign mode_o = (state_reg == pmc_pkg::PMC_DOZE || state_reg == pmc_pkg::PMC_SNOOP) ? 3'h1 :
    (state_reg == pmc_pkg::PMC_NAP) ? 3'h2 : (state_reg == pmc_pkg::PMC_SLEEP) ? 3'h4 : 3'h0;

  //////////////////////////////////////////////////////////////////////
  property p_entry_delay;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_FULL && state_next == pmc_pkg::PMC_ENTER && sel == 3'h1
       && !hard_reset_pin_i) |=> (state_reg != pmc_pkg::PMC_DOZE) [*4] ##1
      (state_reg != pmc_pkg::PMC_ENTER);
  endproperty
  a_entry_delay: assert property (p_entry_delay) else $error("doze entry timing wrong");
  property p_no_same_cycle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_reg == pmc_pkg::PMC_FULL |=> state_reg != pmc_pkg::PMC_DOZE;
  endproperty
  a_no_same_cycle: assert property (p_no_same_cycle) else $error("doze entered at once");
  property p_no_mode_hop;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (mode_o != 3'h0) |=> (mode_o == $past(mode_o) || mode_o == 3'h0);
  endproperty
  a_no_mode_hop: assert property (p_no_mode_hop) else $error("direct mode change");
  property p_multi_bits;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_FULL && pow_invoke_i && !one_hot) |=>
      state_reg == pmc_pkg::PMC_FULL;
  endproperty
  a_multi_bits: assert property (p_multi_bits) else $error("invalid mode entered");
  property p_quiesce_acknowledge_gate;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_QUIESCE && !quiesce_acknowledge_i && !sleep_wake
       && !hard_reset_pin_i) |=> state_reg == pmc_pkg::PMC_QUIESCE && quiesce_request_o;
  endproperty
  a_quiesce_acknowledge_gate: assert property (p_quiesce_acknowledge_gate) else $error("entered without acknowledge");
  property p_sleep_nosnoop;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_reg == pmc_pkg::PMC_SLEEP |-> !snoop_enable_o && quiesce_request_o;
  endproperty
  a_sleep_nosnoop: assert property (p_sleep_nosnoop) else $error("snoop in sleep");
  property p_nap_snoop_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_QUIESCE && state_next == pmc_pkg::PMC_NAP) |=>
      !snoop_enable_o;
  endproperty
  a_nap_snoop_off: assert property (p_nap_snoop_off) else $error("snoop open on nap entry");
  property p_doze_wake;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_DOZE && doze_wake) |=> state_reg == pmc_pkg::PMC_FULL && wake_o;
  endproperty
  a_doze_wake: assert property (p_doze_wake) else $error("doze wake missed");
  property p_snoop_return;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_DOZE && snoop_hit_i && !doze_wake) |=>
      writeback_o && dcache_enable_o ##1 writeback_o;
  endproperty
  a_snoop_return: assert property (p_snoop_return) else $error("snoop writeback wrong");
  property p_full_clocks;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_reg == pmc_pkg::PMC_FULL && !cfg_reg[pmc_pkg::GATING_BIT]) ##1
      (state_reg == pmc_pkg::PMC_FULL) |-> unit_clk_en_o == {UNITS{1'b1}};
  endproperty
  a_full_clocks: assert property (p_full_clocks) else $error("unit clock stopped");
  property p_hard_reset_pin;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      hard_reset_pin_i |=> state_reg == pmc_pkg::PMC_FULL && !cfg_reg[pmc_pkg::GATING_BIT];
  endproperty
  a_hard_reset_pin: assert property (p_hard_reset_pin) else $error("hard reset state wrong");
endmodule

// ---- include/pmc_pkg.sv ----
// Package: constants and types for the power mode controller
package pmc_pkg;
  localparam int CFG_W = 32;
  localparam int DOZE_BIT = 8;
  localparam int NAP_BIT = 9;
  localparam int SLEEP_BIT = 10;
  localparam int GATING_BIT = 11;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int ENTRY_CYCLES = 4;
  localparam int DEC_W = 32;
  localparam int UNIT_COUNT = 4;
  localparam int SNOOP_WB_CYCLES = 2;
  localparam int QUIESCE_ACKNOWLEDGE_LOW_BUS_CYCLES = 8;
  typedef enum logic [2:0] {PMC_FULL, PMC_ENTER, PMC_QUIESCE, PMC_DOZE, PMC_NAP, PMC_SLEEP,
    PMC_SNOOP} pmc_state_type;
endpackage

// ---- include/pmc_gate_if.sv ----
// Interface: per-unit clock enable request and grant
`timescale 1ns/1ns
interface pmc_gate_if #(parameter int N = 4);
  logic gating_en;
  logic core_run;
  logic [N-1:0] unit_need;
  logic [N-1:0] unit_clk_en;
  modport ctrl (output gating_en, output core_run, output unit_need, input unit_clk_en);
  modport gate (input gating_en, input core_run, input unit_need, output unit_clk_en);
endinterface

// ---- rtl/pmc_unit_gate.sv ----
// Per-unit clock enable generation
`timescale 1ns/1ns
module pmc_unit_gate #(parameter int N = 4)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  pmc_gate_if.gate g
);
  logic [N-1:0] en_reg;
  logic [N-1:0] en_next;

  // One enable per unit, registered to stay glitch free at the gate cell
  genvar k;
  generate
    for (k = 0; k < N; k++)
    begin : g_unit
      always_comb
      begin
        en_next[k] = g.core_run & (~g.gating_en | g.unit_need[k]);
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      en_reg <= {N{1'b1}};
    else
      en_reg <= en_next;
  end

  // Registered enable follows need by one cycle; units request one cycle ahead
  assign g.unit_clk_en = en_reg;
endmodule

// ---- bench/pmc_sys_model.sv ----
// System-side model: quiesce acknowledge and bus clock pulses
`timescale 1ns/1ns
module pmc_sys_model #(parameter int ACK_DELAY = 3)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic quiesce_request_i,
  input wire logic snoop_req_i,
  output logic quiesce_acknowledge_o,
  output logic bus_clk_en_o
);
  int wait_cnt;
  //////////////////////////////
  // Bus clock is half the core rate, so eight bus clocks span sixteen core cycles
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_cnt <= 0;
      quiesce_acknowledge_o <= 1'b0;
      bus_clk_en_o <= 1'b0;
    end
    else
    begin
      bus_clk_en_o <= !bus_clk_en_o;
      if (!quiesce_request_i || snoop_req_i)
      begin
        wait_cnt <= 0;
        quiesce_acknowledge_o <= 1'b0;
      end
      else if (wait_cnt < ACK_DELAY)
        wait_cnt <= wait_cnt + 1;
      else
        quiesce_acknowledge_o <= 1'b1;
    end
  end
endmodule

// ---- bench/test_pmc_power_mode_controller.sv ----
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
module test_pmc_power_mode_controller;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cfg_we = 1'b0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic invoke = 1'b0;
  logic [3:0] need = 4'h0;
  logic [6:0] wk = 7'h00;
  logic hard_rst = 1'b0;
  logic dec_load = 1'b0;
  logic [31:0] dec_value = 32'h0000_0000;
  logic snoop_hit = 1'b0;
  logic snoop_req = 1'b0;
  logic quiesce_acknowledge, bus_en, dec_irq, quiesce_request, snoop_en, dc_en, wb, tb_run, pll_lock;
  logic smi_take, ext_take, wake;
  logic [31:0] cfg_q, dec_cnt;
  logic [3:0] clk_en;
  logic [2:0] mode;
  int fail_count = 0;
  int samples_checked = 0;
  //////////////////////////////
  pmc_power_mode_controller dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .cfg_we_i(cfg_we), .cfg_wdata_i(cfg_wdata), .hw_config_register_o(cfg_q),
    .pow_invoke_i(invoke), .unit_need_i(need), .unit_clk_en_o(clk_en),
    .ext_interrupt_i(wk[0]), .system_mgmt_interrupt_i(wk[1]), .machine_check_pin_i(wk[2]),
    .machine_check_i(wk[3]), .perf_mon_interrupt_i(wk[4]), .thermal_interrupt_i(wk[5]),
    .soft_reset_i(wk[6]), .hard_reset_pin_i(hard_rst), .dec_load_i(dec_load),
    .dec_value_i(dec_value), .dec_count_o(dec_cnt), .dec_interrupt_o(dec_irq),
    .snoop_hit_i(snoop_hit), .quiesce_request_o(quiesce_request), .quiesce_acknowledge_i(quiesce_acknowledge),
    .bus_clk_en_i(bus_en), .snoop_enable_o(snoop_en), .dcache_enable_o(dc_en),
    .writeback_o(wb), .timebase_run_o(tb_run), .pll_keep_lock_o(pll_lock),
    .smi_vector_take_o(smi_take), .ext_vector_take_o(ext_take), .wake_o(wake), .mode_o(mode));
  pmc_sys_model sys (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .quiesce_request_i(quiesce_request),
    .snoop_req_i(snoop_req), .quiesce_acknowledge_o(quiesce_acknowledge), .bus_clk_en_o(bus_en));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  //////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [2:0] pick(input int sel);
    case (sel)
      0: return mode;
      1: return {2'b00, quiesce_request};
      2: return {2'b00, snoop_en};
      default: return {2'b00, wb};
    endcase
  endfunction
  // Bounded wait; running out of cycles ends the run
  task automatic wait_val(input string what, input int sel, input logic [2:0] exp, input int n);
    for (int i = 0; i < n && pick(sel) !== exp; i++)
      tick();
    chk_word(what, {29'h0, exp}, {29'h0, pick(sel)});
    if (pick(sel) !== exp)
      wrap_up();
  endtask
  task automatic wr_cfg(input logic [31:0] d);
    tick();
    cfg_we = 1'b1;
    cfg_wdata = d;
    tick();
    cfg_we = 1'b0;
    chk_word("config", d, cfg_q);
  endtask
  task automatic go(input logic [31:0] d);
    wr_cfg(d);
    invoke = 1'b1;
    tick();
    invoke = 1'b0;
  endtask
  task automatic wake_by(input int s);
    wk[s] = 1'b1;
    #1;
    if (s == 0)
      chk_bit("ext vector", 1'b1, ext_take);
    if (s == 1)
      chk_bit("smi vector", 1'b1, smi_take);
    wait_val("mode", 0, 3'h0, 4);
    chk_bit("wake", 1'b1, wake);
    wk[s] = 1'b0;
  endtask
  //////////////////////////////
  initial
  begin
    tick(2);
    reset_n_i = 1'b1;
    chk_word("config", 32'h0000_0000, cfg_q);
    chk_word("unit enables", 32'h0000_000F, {28'h0, clk_en});
    chk_bit("quiesce request", 1'b0, quiesce_request);
    need = 4'h5;
    wr_cfg(32'h0000_0800);
    tick(2);
    chk_word("unit enables", 32'h0000_0005, {28'h0, clk_en});
    need = 4'hA;
    tick(2);
    chk_word("unit enables", 32'h0000_000A, {28'h0, clk_en});
    wr_cfg(32'h0000_0000);
    tick(2);
    chk_word("unit enables", 32'h0000_000F, {28'h0, clk_en});
    $display("test gating done");
    for (int s = 0; s < 7; s++)
    begin
      go(32'h0000_0100);
      chk_word("mode", 32'h0, {29'h0, mode});
      wait_val("mode", 0, 3'h1, 8);
      chk_bit("snoop", 1'b1, snoop_en);
      chk_bit("time base", 1'b1, tb_run);
      chk_bit("pll lock", 1'b1, pll_lock);
      if (s == 0)
      begin
        snoop_hit = 1'b1;
        tick();
        snoop_hit = 1'b0;
        wait_val("writeback", 3, 3'h1, 6);
        chk_bit("dcache", 1'b1, dc_en);
        tick(6);
        chk_word("mode", 32'h1, {29'h0, mode});
        chk_bit("dcache", 1'b0, dc_en);
      end
      wake_by(s);
    end
    $display("test doze done");
    go(32'h0000_0300);
    tick(8);
    chk_word("mode", 32'h0, {29'h0, mode});
    go(32'h0000_0100);
    wait_val("mode", 0, 3'h1, 8);
    go(32'h0000_0200);
    tick(8);
    chk_word("mode", 32'h1, {29'h0, mode});
    chk_bit("quiesce request", 1'b0, quiesce_request);
    wake_by(0);
    $display("test refusals done");
    go(32'h0000_0200);
    wait_val("quiesce request", 1, 3'h1, 6);
    chk_word("mode", 32'h0, {29'h0, mode});
    wait_val("mode", 0, 3'h2, 12);
    chk_bit("snoop", 1'b0, snoop_en);
    wk[4] = 1'b1;
    tick(4);
    chk_word("mode", 32'h2, {29'h0, mode});
    wk[4] = 1'b0;
    snoop_req = 1'b1;
    tick(10);
    chk_bit("snoop", 1'b0, snoop_en);
    wait_val("snoop", 2, 3'h1, 30);
    snoop_req = 1'b0;
    wait_val("snoop", 2, 3'h0, 12);
    wake_by(0);
    $display("test nap done");
    go(32'h0000_0400);
    wait_val("mode", 0, 3'h4, 16);
    chk_bit("time base", 1'b0, tb_run);
    chk_bit("snoop", 1'b0, snoop_en);
    wake_by(1);
    $display("test sleep done");
    dec_load = 1'b1;
    dec_value = 32'h0000_0014;
    tick();
    dec_load = 1'b0;
    chk_word("decrementer", 32'h0000_0014, dec_cnt);
    go(32'h0000_0100);
    wait_val("mode", 0, 3'h1, 8);
    chk_word("decrementer", 32'h0000_000D, dec_cnt);
    wait_val("mode", 0, 3'h0, 40);
    chk_bit("wake", 1'b1, wake);
    chk_bit("dec interrupt", 1'b1, dec_irq);
    tick();
    chk_bit("dec interrupt", 1'b0, dec_irq);
    $display("test decrementer done");
    wr_cfg(32'h0000_0900);
    hard_rst = 1'b1;
    tick();
    hard_rst = 1'b0;
    chk_word("config", 32'h0000_0000, cfg_q);
    // Unit enables are registered, so they follow the cleared gating bit one cycle later
    tick();
    chk_word("unit enables", 32'h0000_000F, {28'h0, clk_en});
    $display("test hard reset done");
    wrap_up();
  end
endmodule
